// ===== dbq_board.sv
`timescale 1ns/1ns

// board wiring and count source in front of both counter halves
module dbq_board
(
    input  wire logic [1:0] i_mode,  // 0 decade, 1 bi-quinary, 2 separate pins
    input  wire logic       i_src,
    input  wire logic       i_aux,
    input  wire logic       i_half_q,
    input  wire logic       i_quint_d,
    output logic            o_half_clk,
    output logic            o_quint_clk
);
    // ripple links are plain wires, so the counter sees its own outputs as clocks
    always_comb
    begin
        o_half_clk  = i_src;
        o_quint_clk = i_half_q;
        if (i_mode == 2'h1)
        begin
            o_half_clk  = i_quint_d;
            o_quint_clk = i_src;
        end
        else if (i_mode == 2'h2)
        begin
            o_quint_clk = i_aux;
        end
    end
endmodule : dbq_board

// ===== dbq_counter.sv
`timescale 1ns/1ns

module dbq_counter
(
    input  wire logic i_mclk,
    input  wire logic i_sys_rst,
    input  wire logic i_clk_en,
    input  wire logic i_half_clk,
    input  wire logic i_quint_clk,
    input  wire logic i_stage_rst,
    output logic      o_half_stage_out,
    output logic      o_quint_bit_b,
    output logic      o_quint_bit_c,
    output logic      o_quint_bit_d
);
    import dbq_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    dbq_pin_if pin_bus ();

    logic [PIN_COUNT-1:0] raw_pins;

    // pin order fixed by the package indices
    always_comb
    begin
        raw_pins            = '0;
        raw_pins[PIN_HALF]  = i_half_clk;
        raw_pins[PIN_QUINT] = i_quint_clk;
        raw_pins[PIN_RST]   = i_stage_rst;
    end

    dbq_pin_sync #(
        .WIDTH     (PIN_COUNT)
    ) u_pin_sync (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_pins    (raw_pins),
        .pins      (pin_bus)
    );

    // ------------------------------------------------------------------
    // decoded stage events
    // ------------------------------------------------------------------
    logic stage_rst;
    logic half_fall;
    logic quint_fall;

    // reset is a level: sampled like any pin, so it lands two cycles late;
    // the trade is a clean single-clock design against a short clear lag
    assign stage_rst  = pin_bus.level[PIN_RST];
    assign half_fall  = pin_bus.fall[PIN_HALF];
    assign quint_fall = pin_bus.fall[PIN_QUINT];

    // ------------------------------------------------------------------
    // counting state
    // ------------------------------------------------------------------
    logic               half;
    logic [QUINT_W-1:0] quint;
    logic               next_half;
    logic [QUINT_W-1:0] next_quint;

    // wrap test is shared by the counter and its checks
    function automatic logic quint_at_last(input logic [QUINT_W-1:0] q);
        quint_at_last = (q >= QUINT_LAST);
    endfunction : quint_at_last

    // both sections step independently, so coincident edges step both at once; reset clears both at once
    always_comb
    begin
        next_half  = half;
        next_quint = quint;
        if (i_clk_en)
        begin
            if (stage_rst)
            begin
                next_half  = HALF_RST;
                next_quint = QUINT_RST;
            end
            else
            begin
                if (half_fall)
                begin
                    next_half = ~half;
                end
                if (quint_fall)
                begin
                    // 5..7 cannot be reached; treat them as last to recover
                    if (quint_at_last(quint))
                    begin
                        next_quint = QUINT_RST;
                    end
                    else
                    begin
                        next_quint = quint + 3'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            half  <= HALF_RST;
            quint <= QUINT_RST;
        end
        else
        begin
            half  <= next_half;
            quint <= next_quint;
        end
    end

    // outputs come straight from the counting flops
    assign o_half_stage_out = half;
    assign o_quint_bit_b    = quint[0];
    assign o_quint_bit_c    = quint[1];
    assign o_quint_bit_d    = quint[2];

    // ------------------------------------------------------------------
    // helper logic for checks
    // ------------------------------------------------------------------
    logic [QUINT_W-1:0] steps_since_wrap;
    logic [QUINT_W-1:0] next_steps;

    // counts five-stage advances since its last wrap or reset
    always_comb
    begin
        next_steps = steps_since_wrap;
        if (i_clk_en)
        begin
            if (stage_rst)
            begin
                next_steps = QUINT_RST;
            end
            else if (quint_fall)
            begin
                if (quint_at_last(steps_since_wrap))
                begin
                    next_steps = QUINT_RST;
                end
                else
                begin
                    next_steps = steps_since_wrap + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            steps_since_wrap <= QUINT_RST;
        end
        else
        begin
            steps_since_wrap <= next_steps;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking

    default disable iff (i_sys_rst);

    // the two-stage section ignores five-stage edges
    a_stage_independent: assert property (
        (i_clk_en && !stage_rst && quint_fall && !half_fall)
        |=> ($stable(o_half_stage_out))
    ) else $error("two-stage moved on a five-stage edge");

    // five-stage never leaves 0..4, so decade value stays at or below 9
    a_quint_range: assert property (
        ({o_quint_bit_d, o_quint_bit_c, o_quint_bit_b} <= QUINT_LAST)
    ) else $error("five-stage left its 0 to 4 range");

    // wrap from 4 to 0 on the next five-stage edge
    a_quint_wrap_zero: assert property (
        (i_clk_en && !stage_rst && quint_fall && quint == QUINT_LAST)
        |=> (quint == QUINT_RST)
    ) else $error("five-stage did not wrap from 4 to 0");

    // bit d falls only after exactly five advances, giving the 5/5 half clock
    a_square_period: assert property (
        (i_clk_en && !stage_rst && quint_fall)
        |=> ($fell(o_quint_bit_d) == (steps_since_wrap == QUINT_RST))
    ) else $error("five-stage wrap not every fifth edge");

    // no edge on either stage clock means no change anywhere
    a_falling_only: assert property (
        (!half_fall && !quint_fall && !stage_rst)
        |=> ($stable(half) && $stable(quint))
    ) else $error("counter moved without a falling edge");

    // reset held for two cycles leaves all outputs low
    a_reset_clear: assert property (
        (i_clk_en && stage_rst) ##1 stage_rst
        |-> (!o_half_stage_out && !o_quint_bit_b && !o_quint_bit_c && !o_quint_bit_d)
    ) else $error("outputs not cleared under reset");

    // each two-stage falling edge inverts the output one cycle later
    a_half_toggle: assert property (
        (i_clk_en && !stage_rst && half_fall)
        |=> (o_half_stage_out != $past(o_half_stage_out))
    ) else $error("two-stage did not toggle on its edge");

    // a frozen enable holds every counting flop
    a_enable_freeze: assert property (
        (!i_clk_en) |=> ($stable(half) && $stable(quint))
    ) else $error("state moved while clock enable was low");

endmodule : dbq_counter

// ===== dbq_pin_if.sv
`timescale 1ns/1ns

// synchronised pin levels and one-cycle falling-edge pulses
interface dbq_pin_if;
    import dbq_pkg::*;
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] fall;

    modport sync (output level, output fall);
    modport user (input level, input fall);
endinterface : dbq_pin_if

// ===== dbq_pin_sync.sv
`timescale 1ns/1ns

module dbq_pin_sync
#(
    parameter int unsigned WIDTH = dbq_pkg::PIN_COUNT
)
(
    input  wire logic             i_mclk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_clk_en,
    input  wire logic [WIDTH-1:0] i_pins,
    dbq_pin_if.sync               pins
);
    import dbq_pkg::*;

    // ------------------------------------------------------------------
    // two-flop synchroniser plus falling-edge detector per pin
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_pin
            logic meta;
            logic stable;
            logic prev;
            logic next_meta;
            logic next_stable;
            logic next_prev;

            // first flop feeds only the second; edges are seen one stage later
            always_comb
            begin
                next_meta   = meta;
                next_stable = stable;
                next_prev   = prev;
                if (i_clk_en)
                begin
                    next_meta   = i_pins[g];
                    next_stable = meta;
                    next_prev   = stable;
                end
            end

            always_ff @(posedge i_mclk)
            begin
                if (i_sys_rst)
                begin
                    meta   <= SYNC_RST;
                    stable <= SYNC_RST;
                    prev   <= SYNC_RST;
                end
                else
                begin
                    meta   <= next_meta;
                    stable <= next_stable;
                    prev   <= next_prev;
                end
            end

            // high-to-low transition seen across the last two stages
            assign pins.level[g] = stable;
            assign pins.fall[g]  = prev & ~stable;
        end
    endgenerate

endmodule : dbq_pin_sync

// ===== dbq_pkg.sv
package dbq_pkg;

    // ------------------------------------------------------------------
    // pin map and widths
    // ------------------------------------------------------------------
    localparam int unsigned PIN_COUNT   = 3;
    localparam int unsigned PIN_HALF    = 0;  // divide-by-two clock pin
    localparam int unsigned PIN_QUINT   = 1;  // divide-by-five clock pin
    localparam int unsigned PIN_RST     = 2;  // shared counter reset pin
    localparam int unsigned QUINT_W     = 3;

    // ------------------------------------------------------------------
    // count values and reset values
    // ------------------------------------------------------------------
    localparam logic [QUINT_W-1:0] QUINT_LAST  = 3'h4;
    localparam logic [QUINT_W-1:0] QUINT_RST   = 3'h0;
    localparam logic               HALF_RST    = 1'h0;
    localparam logic               SYNC_RST    = 1'h0;

endpackage : dbq_pkg

// ===== tb_dbq_counter.sv
`timescale 1ns/1ns

module tb_dbq_counter;
    logic       i_mclk    = 1'h0;
    logic       i_sys_rst = 1'h1;
    logic       clk_en    = 1'h1;
    logic       stage_rst = 1'h1;
    logic [1:0] mode      = 2'h0;
    logic       src       = 1'h1;
    logic       aux       = 1'h1;
    logic [1:0] r;
    logic       half_clk, quint_clk, q_a, q_b, q_c, q_d;
    int         mismatches = 0;
    int         n_tests    = 0;
    int         cnt, h, q;

    // free-running system clock, 50 ns period
    initial
    begin
        forever #25 i_mclk = ~i_mclk;
    end

    dbq_counter dbq_counter_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en),
        .i_half_clk(half_clk), .i_quint_clk(quint_clk), .i_stage_rst(stage_rst),
        .o_half_stage_out(q_a), .o_quint_bit_b(q_b), .o_quint_bit_c(q_c),
        .o_quint_bit_d(q_d));

    dbq_board dbq_board_i (.i_mode(mode), .i_src(src), .i_aux(aux), .i_half_q(q_a),
        .i_quint_d(q_d), .o_half_clk(half_clk), .o_quint_clk(quint_clk));

    // inputs always move 2 ns after the rising edge
    task automatic tick(input int k);
        repeat (k)
        begin
            @(posedge i_mclk);
            #2;
        end
    endtask : tick

    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("mismatches %0d checks %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // 8 cycles low covers the two-stage ripple; the rising half must not count
    task automatic pulse(input logic [1:0] sel);
        src = !sel[0];
        aux = !sel[1];
        tick(8);
        src = 1'h1;
        aux = 1'h1;
        tick(8);
    endtask : pulse

    // mode pins swap only under counter reset, so the swap glitch is ignored
    task automatic restart(input logic [1:0] m);
        stage_rst = 1'h1;
        tick(4);
        mode = m;
        tick(4);
        check("reset", {q_d, q_c, q_b, q_a}, 4'h0);
        stage_rst = 1'h0;
        tick(4);
        cnt = 0;
        h   = 0;
        q   = 0;
    endtask : restart

    // hang guard, well beyond the roughly 1600 cycles the tests need
    initial
    begin
        #200000;
        mismatches++;
        stop_test();
    end

    // main sequence: decade, reset mid-count, bi-quinary, separate stages
    initial
    begin
        void'($urandom(32'h0E8F));
        tick(16);
        i_sys_rst = 1'h0;
        tick(2);
        restart(2'h0);
        repeat (20 + $urandom_range(0, 9))
        begin
            pulse(2'h1);
            cnt = (cnt + 1) % 10;
            check("bcd", {q_d, q_c, q_b, q_a}, 4'(cnt));
        end
        // source edges while reset is held must be ignored
        stage_rst = 1'h1;
        pulse(2'h1);
        pulse(2'h1);
        check("held", {q_d, q_c, q_b, q_a}, 4'h0);
        restart(2'h1);
        repeat (25)
        begin
            pulse(2'h1);
            q = (q + 1) % 5;
            if (q == 0)
                h = 1 - h;
            check("biq", {q_a, q_d, q_c, q_b}, 4'(h * 8 + q));
        end
        restart(2'h2);
        repeat (40)
        begin
            r = 2'($urandom_range(1, 3));
            pulse(r);
            if (r[0])
                h = 1 - h;
            if (r[1])
                q = (q + 1) % 5;
            check("split", {q_a, q_d, q_c, q_b}, 4'(h * 8 + q));
        end
        // a whole pulse under a frozen enable never reaches the synchroniser
        clk_en = 1'h0;
        pulse(2'h3);
        check("frozen", {q_a, q_d, q_c, q_b}, 4'(h * 8 + q));
        clk_en = 1'h1;
        tick(4);
        check("thawed", {q_a, q_d, q_c, q_b}, 4'(h * 8 + q));
        // counting must resume on the first pulse after the enable returns
        pulse(2'h3);
        h = 1 - h;
        q = (q + 1) % 5;
        check("resumed", {q_a, q_d, q_c, q_b}, 4'(h * 8 + q));
        stop_test();
    end
endmodule : tb_dbq_counter
